//--- src/vect_core.sv
// Reset and interrupt vectoring: program counter load, cause flags, stack, shadow buffer.
// Assumes a sequencer that presents one-cycle commands and holds fetch while busy.
`default_nettype none
module vect_core (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic power_on_rst,
  input wire logic watchdog_rst,
  input wire logic reset_pin_n,
  input wire vect_pkg::irq_req_t irq_req,
  input wire logic irq_enable,
  input wire vect_pkg::seq_cmd_t cmd,
  input wire logic acc_wr,
  input wire logic [7:0] acc_wdata,
  input wire logic flag_wr,
  input wire logic [7:0] flag_wdata,
  input wire logic bank_wr,
  input wire logic bank_wdata,
  output logic [13:0] pc_load,
  output logic pc_load_valid,
  output logic [7:0] accumulator,
  output logic [7:0] program_flag_register,
  output logic ram_bank_select,
  output logic [3:0] stack_level,
  output logic irq_taken
);
  // Two-stage synchroniser on the external reset pin, reset to released.
  logic pin_s1_ff;
  logic pin_s2_ff;
  // Core state registers.
  logic [13:0] pc_load_ff;
  logic pc_load_valid_ff;
  logic [7:0] acc_ff;
  logic [7:0] flag_ff;
  logic [7:0] shadow_acc_ff;
  logic [7:0] shadow_flag_ff;
  logic bank_ff;
  logic [3:0] sp_ff;
  logic irq_taken_ff;
  logic pop_pend_ff;
  // Stack memory read data.
  logic [13:0] top_data;

  // The pin is resynchronised; its reset value is the released level.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_s1_ff <= 1'b1;
      pin_s2_ff <= 1'b1;
    end else begin
      pin_s1_ff <= reset_pin_n;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  wire pin_rst = ~pin_s2_ff;
  // Any reset source, including the system reset itself.
  wire any_rst = sys_rst | power_on_rst | watchdog_rst | pin_rst;
  wire irq_any = irq_req.basic_timer | irq_req.timer_capture_unit | irq_req.external_irq_input;
  // Stack full and empty tests.
  wire stack_full = (sp_ff == 4'(vect_pkg::STACK_DEPTH));
  wire stack_empty = (sp_ff == vect_pkg::SP_EMPTY);
  wire take_irq = irq_any & irq_enable & ~any_rst & ~irq_taken_ff & ~pop_pend_ff;
  // Pushes come from interrupts and calls; a full stack wraps onto its oldest level.
  wire do_push = take_irq | (cmd.call & ~any_rst & ~take_irq);
  wire do_pop = (cmd.ret | cmd.irq_ret) & ~any_rst & ~take_irq & ~stack_empty & ~pop_pend_ff;
  wire [13:0] push_data = cmd.pc;
  wire [2:0] wr_idx = sp_ff[2:0];
  wire [2:0] rd_idx = 3'(sp_ff - 4'h1);

  vect_stack #(
    .DEPTH(vect_pkg::STACK_DEPTH),
    .WIDTH(vect_pkg::PC_W),
    .IDX_W(3)
  ) u_stack (
    .clk(clk),
    .wr_en(do_push),
    .wr_idx(wr_idx),
    .wr_data(push_data),
    .rd_idx(rd_idx),
    .rd_data(top_data)
  );

  // Cause flag value for the reset that fires; power-on outranks pin, pin outranks watchdog.
  // reset-cause flags
  wire nxt_timeout = (sys_rst | power_on_rst) ? 1'b1 : (pin_rst ? 1'b1 : 1'b0);
  wire nxt_pwrdn = (sys_rst | power_on_rst) ? 1'b0 : (pin_rst ? 1'b1 : 1'b0);

  wire [7:0] restored_flag = (flag_ff & vect_pkg::CAUSE_MASK) | (shadow_flag_ff & ~vect_pkg::CAUSE_MASK);
  wire [7:0] written_flag = (flag_ff & vect_pkg::CAUSE_MASK) | (flag_wdata & ~vect_pkg::CAUSE_MASK);

  // Program counter loads: reset vector, interrupt vector, or popped return address.
  always_ff @(posedge clk) begin
    if (any_rst) begin
      pc_load_ff <= vect_pkg::RESET_VECTOR;
      pc_load_valid_ff <= 1'b1;
      pop_pend_ff <= 1'b0;
    end else if (take_irq) begin
      pc_load_ff <= vect_pkg::IRQ_VECTOR;
      pc_load_valid_ff <= 1'b1;
      pop_pend_ff <= 1'b0;
    end else if (pop_pend_ff) begin
      pc_load_ff <= top_data;
      pc_load_valid_ff <= 1'b1;
      pop_pend_ff <= 1'b0;
    end else begin
      pc_load_valid_ff <= 1'b0;
      pop_pend_ff <= do_pop;
    end
  end

  // Stack pointer and the interrupt-taken strobe.
  always_ff @(posedge clk) begin
    if (any_rst) begin
      sp_ff <= vect_pkg::SP_EMPTY;
      irq_taken_ff <= 1'b0;
    end else begin
      irq_taken_ff <= take_irq;
      if (do_push && !stack_full) begin
        sp_ff <= sp_ff + 4'h1;
      end else if (pop_pend_ff) begin
        sp_ff <= sp_ff - 4'h1;
      end
    end
  end

  // Accumulator, flags and the one-level shadow buffer.
  always_ff @(posedge clk) begin
    if (any_rst) begin
      acc_ff <= vect_pkg::ACC_RESET;
      flag_ff <= vect_pkg::FLAG_RESET;
      flag_ff[vect_pkg::TIMEOUT_BIT] <= nxt_timeout;
      flag_ff[vect_pkg::PWRDN_BIT] <= nxt_pwrdn;
      shadow_acc_ff <= vect_pkg::ACC_RESET;
      shadow_flag_ff <= vect_pkg::FLAG_RESET;
    end else begin
      if (cmd.save) begin
        shadow_acc_ff <= acc_ff;
        shadow_flag_ff <= flag_ff;
      end
      if (cmd.restore) begin
        acc_ff <= shadow_acc_ff;
        flag_ff <= restored_flag;
      end else begin
        if (acc_wr) begin
          acc_ff <= acc_wdata;
        end
        if (flag_wr) begin
          flag_ff <= written_flag;
        end
      end
    end
  end

  // Bank select is software's alone.
  always_ff @(posedge clk) begin
    if (any_rst) begin
      bank_ff <= 1'b0;
    end else if (bank_wr) begin
      bank_ff <= bank_wdata;
    end
  end

  // Outputs straight from flip-flops.
  assign pc_load = pc_load_ff;
  assign pc_load_valid = pc_load_valid_ff;
  assign accumulator = acc_ff;
  assign program_flag_register = flag_ff;
  assign ram_bank_select = bank_ff;
  assign stack_level = sp_ff;
  assign irq_taken = irq_taken_ff;

  // Interrupt entry lands on the shared vector next cycle.
  a_irq_vector: assert property (@(posedge clk) disable iff (sys_rst)
    take_irq |=> (pc_load_ff == vect_pkg::IRQ_VECTOR) && pc_load_valid_ff && irq_taken_ff)
    else $error("interrupt did not load vector");
  // Reset loads the reset vector and empties the stack.
  a_reset_vector: assert property (@(posedge clk)
    any_rst |=> (pc_load_ff == vect_pkg::RESET_VECTOR) && (sp_ff == vect_pkg::SP_EMPTY))
    else $error("reset did not restart at vector");
  a_watchdog_flags: assert property (@(posedge clk)
    (watchdog_rst && !sys_rst && !power_on_rst && !pin_rst) |=> (flag_ff[7:6] == 2'b00))
    else $error("watchdog cause flags wrong");
  a_pin_flags: assert property (@(posedge clk)
    (pin_rst && !sys_rst && !power_on_rst) |=> (flag_ff[7:6] == 2'b11))
    else $error("pin cause flags wrong");
  a_por_flags: assert property (@(posedge clk)
    power_on_rst |=> (flag_ff[7:6] == 2'b10))
    else $error("power-on cause flags wrong");
  a_restore_keeps: assert property (@(posedge clk) disable iff (sys_rst)
    (cmd.restore && !any_rst) |=> (flag_ff[7:6] == $past(flag_ff[7:6])) && (acc_ff == $past(shadow_acc_ff)))
    else $error("restore touched cause flags");
  a_pop_resume: assert property (@(posedge clk) disable iff (sys_rst)
    (do_pop && !any_rst) ##1 !any_rst |=> pc_load_valid_ff && (pc_load_ff == $past(top_data)))
    else $error("return did not resume");
  a_irq_no_rst: assert property (@(posedge clk) disable iff (sys_rst)
    any_rst |-> !take_irq ##1 (!irq_taken_ff && (sp_ff == vect_pkg::SP_EMPTY)))
    else $error("interrupt taken during reset");
  a_bank_kept: assert property (@(posedge clk) disable iff (sys_rst)
    (take_irq && !bank_wr) |=> $stable(bank_ff))
    else $error("bank changed on interrupt");
endmodule : vect_core
`default_nettype wire

//--- src/vect_pkg.sv
// Package for the reset and interrupt vectoring block.
// Assumes one 40 MHz clock and a sequencer that issues one-cycle commands.
`default_nettype none
package vect_pkg;
  // Program counter width covers a 16K-word program store.
  localparam int PC_W = 14;
  // Accumulator and flag register width.
  localparam int DATA_W = 8;
  // Depth of the return-address stack.
  localparam int STACK_DEPTH = 8;
  // Stack pointer width, one bit more than the index so that full is visible.
  localparam int SP_W = 4;
  // Reset vector address.
  localparam logic [13:0] RESET_VECTOR = 14'h0000;
  // Shared interrupt vector address.
  localparam logic [13:0] IRQ_VECTOR = 14'h0008;
  // Bit positions of the reset-cause flags in the program flag register.
  localparam int TIMEOUT_BIT = 7;
  localparam int PWRDN_BIT = 6;
  // Mask of the bits that restore and flag writes keep away from.
  localparam logic [7:0] CAUSE_MASK = 8'hC0;
  // Reset value of the accumulator and the lower flag bits.
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  // Empty stack pointer value.
  localparam logic [3:0] SP_EMPTY = 4'h0;

  // Reset source that fired last.
  typedef enum logic [2:0] {
    CAUSE_POWER_ON = 3'b001,
    CAUSE_WATCHDOG = 3'b010,
    CAUSE_PIN = 3'b100
  } cause_t;

  // One-cycle commands from the instruction sequencer.
  typedef struct packed {
    logic save;
    logic restore;
    logic call;
    logic ret;
    logic irq_ret;
    logic [13:0] pc;
    logic [13:0] target;
  } seq_cmd_t;

  // Three interrupt request lines.
  typedef struct packed {
    logic basic_timer;
    logic timer_capture_unit;
    logic external_irq_input;
  } irq_req_t;
endpackage : vect_pkg
`default_nettype wire

//--- src/vect_stack.sv
// Return-address stack storage, one word per level, registered read data.
// Assumes the owner never writes and reads the same level in one cycle.
`default_nettype none
module vect_stack #(
  parameter int DEPTH = vect_pkg::STACK_DEPTH,
  parameter int WIDTH = vect_pkg::PC_W,
  parameter int IDX_W = 3
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [IDX_W-1:0] rd_idx,
  output logic [WIDTH-1:0] rd_data
);
  // Storage array of return addresses.
  logic [WIDTH-1:0] mem [DEPTH];

  // Writes land at the pushed level.
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // The top entry is read every cycle, so it is ready in the cycle after a pop.
  always_ff @(posedge clk) begin
    rd_data <= mem[rd_idx];
  end
endmodule : vect_stack
`default_nettype wire

//--- test/irq_src_model.sv
// Model of the three interrupt sources that sit outside the vectoring block.
// Assumes the bench pulses fire for one cycle to raise a request.
`default_nettype none
module irq_src_model (
  input wire logic clk,
  input wire logic any_rst,
  input wire logic [2:0] fire,
  input wire logic irq_taken,
  output var vect_pkg::irq_req_t irq_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // three request lines
  // A request stands until the block reports it taken or a reset clears the sources.
  always_ff @(posedge clk) begin
    if (any_rst || irq_taken) begin
      irq_req <= '0;
    end else begin
      irq_req <= irq_req | fire;
    end
  end
endmodule : irq_src_model
`default_nettype wire

//--- test/vect_core_tb.sv
// Bench for the vectoring block: resets, interrupts, stack and shadow buffer.
// Assumes the package and the interrupt source model are compiled first.
`default_nettype none
module vect_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Stimulus, all driven at the rising edge.
  logic clk = 1'b0, sys_rst = 1'b1, power_on_rst = 1'b0, watchdog_rst = 1'b0, reset_pin_n = 1'b1;
  logic acc_wr = 1'b0, flag_wr = 1'b0, bank_wr = 1'b0, bank_wdata = 1'b0;
  logic [7:0] acc_wdata = 8'h00, flag_wdata = 8'h00;
  logic [2:0] fire = 3'h0;
  logic irq_enable = 1'b1;
  vect_pkg::seq_cmd_t cmd = '0;
  vect_pkg::irq_req_t irq_req;
  // Observed outputs.
  logic [13:0] pc_load;
  logic [7:0] accumulator, program_flag_register;
  logic [3:0] stack_level;
  logic pc_load_valid, ram_bank_select, irq_taken;
  int bad_count = 0, total_checks = 0;

  always #12.5 clk = ~clk;

  vect_core i_vect_core (.clk(clk), .sys_rst(sys_rst), .power_on_rst(power_on_rst),
    .watchdog_rst(watchdog_rst), .reset_pin_n(reset_pin_n), .irq_req(irq_req), .irq_enable(irq_enable),
    .cmd(cmd), .acc_wr(acc_wr), .acc_wdata(acc_wdata), .flag_wr(flag_wr), .flag_wdata(flag_wdata),
    .bank_wr(bank_wr), .bank_wdata(bank_wdata), .pc_load(pc_load), .pc_load_valid(pc_load_valid),
    .accumulator(accumulator), .program_flag_register(program_flag_register),
    .ram_bank_select(ram_bank_select), .stack_level(stack_level), .irq_taken(irq_taken));

  irq_src_model i_irq_src_model (.clk(clk), .fire(fire), .irq_taken(irq_taken), .irq_req(irq_req),
    .any_rst(sys_rst | power_on_rst | watchdog_rst | ~reset_pin_n));

  // Waits for n rising edges.
  task automatic cyc(input int n = 1);
    repeat (n) @(posedge clk);
  endtask : cyc

  // Compares one value and counts it.
  task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Drives one cycle of register writes and shadow commands.
  task automatic drive(input logic wr, input logic [7:0] a, input logic [7:0] f, input logic sv, input logic rs);
    cyc();
    acc_wr <= wr;
    acc_wdata <= a;
    flag_wr <= wr;
    flag_wdata <= f;
    cmd.save <= sv;
    cmd.restore <= rs;
  endtask : drive

  // Two saves then a restore: only the later save survives, cause bits stay.
  task automatic shadow_test;
    // A restore from the cleared buffer must keep the power-on cause bits.
    drive(1'b0, 8'h00, 8'h00, 1'b0, 1'b1);
    drive(1'b0, 8'h00, 8'h00, 1'b0, 1'b0);
    #1;
    chk("restore flags", 14'h0080, 14'(program_flag_register));
    drive(1'b1, 8'h5A, 8'hFC, 1'b0, 1'b0);
    drive(1'b0, 8'h00, 8'h00, 1'b1, 1'b0);
    drive(1'b1, 8'hA5, 8'h03, 1'b0, 1'b0);
    drive(1'b0, 8'h00, 8'h00, 1'b1, 1'b0);
    drive(1'b1, 8'h11, 8'h15, 1'b0, 1'b0);
    drive(1'b0, 8'h00, 8'h00, 1'b0, 1'b1);
    drive(1'b0, 8'h00, 8'h00, 1'b0, 1'b0);
    #1;
    chk("acc", 14'h00A5, 14'(accumulator));
    chk("flags", 14'h0083, 14'(program_flag_register));
  endtask : shadow_test

  // Takes one interrupt and checks vector, push, latency and bank.
  task automatic take_irq(input int src, input logic [13:0] ret_pc);
    int n;
    logic [3:0] lvl;
    lvl = stack_level;
    cyc();
    cmd.pc <= ret_pc;
    fire <= 3'(1 << src);
    cyc();
    fire <= 3'h0;
    n = 0;
    #1;
    while (irq_taken !== 1'b1 && n < 8) begin
      cyc();
      #1;
      n++;
    end
    chk("latency", 14'h0001, 14'(n));
    chk("vector", 14'h0008, pc_load);
    chk("valid", 14'h0001, 14'(pc_load_valid));
    chk("level", 14'(lvl) + 14'h0001, 14'(stack_level));
    chk("bank", 14'h0001, 14'(ram_bank_select));
  endtask : take_irq

  // Returns from an interrupt and checks the popped address.
  task automatic do_ret(input logic [13:0] exp_pc, input logic [3:0] exp_lvl, input logic exp_v);
    cyc();
    cmd.irq_ret <= 1'b1;
    cyc();
    cmd.irq_ret <= 1'b0;
    cyc();
    #1;
    chk("ret pc", exp_pc, pc_load);
    chk("ret valid", 14'(exp_v), 14'(pc_load_valid));
    chk("ret level", 14'(exp_lvl), 14'(stack_level));
  endtask : do_ret

  // Calls once, then returns with the plain return command; the pushed address comes back.
  task automatic call_ret(input logic [13:0] ret_pc);
    cyc();
    cmd.pc <= ret_pc;
    cmd.call <= 1'b1;
    cyc();
    cmd.call <= 1'b0;
    #1;
    chk("call level", 14'h0001, 14'(stack_level));
    chk("call valid", 14'h0000, 14'(pc_load_valid));
    cyc();
    cmd.ret <= 1'b1;
    cyc();
    cmd.ret <= 1'b0;
    cyc();
    #1;
    chk("call pc", ret_pc, pc_load);
    chk("call ret valid", 14'h0001, 14'(pc_load_valid));
    chk("call ret level", 14'h0000, 14'(stack_level));
  endtask : call_ret

  // A request held off while interrupts are disabled is taken once they are enabled.
  task automatic masked_irq;
    cyc();
    irq_enable <= 1'b0;
    fire <= 3'h4;
    cyc();
    fire <= 3'h0;
    cyc(3);
    #1;
    chk("masked level", 14'h0000, 14'(stack_level));
    chk("masked taken", 14'h0000, 14'(irq_taken));
    cyc();
    irq_enable <= 1'b1;
    cyc();
    #1;
    chk("enabled taken", 14'h0001, 14'(irq_taken));
    chk("enabled vector", 14'h0008, pc_load);
    chk("enabled level", 14'h0001, 14'(stack_level));
  endtask : masked_irq

  // Raises a request, then holds one reset source over it for five edges.
  task automatic hit_reset(input int src, input logic [1:0] cause);
    cyc();
    fire <= 3'h1;
    cyc();
    fire <= 3'h0;
    power_on_rst <= (src == 0);
    watchdog_rst <= (src == 1);
    reset_pin_n <= (src != 2);
    cyc(4);
    #1;
    chk("rst pc", 14'h0000, pc_load);
    chk("rst acc", 14'h0000, 14'(accumulator));
    chk("rst cause", 14'(cause), 14'(program_flag_register[7:6]));
    chk("rst level", 14'h0000, 14'(stack_level));
    cyc();
    power_on_rst <= 1'b0;
    watchdog_rst <= 1'b0;
    reset_pin_n <= 1'b1;
    cyc(5);
    #1;
    chk("run valid", 14'h0000, 14'(pc_load_valid));
    chk("run cause", 14'(cause), 14'(program_flag_register[7:6]));
  endtask : hit_reset

  // Prints the verdict and ends the run.
  task automatic print_verdict;
    if (bad_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  // Main sequence: reset, shadow, full stack, then each reset source.
  initial begin
    cyc(2);
    sys_rst <= 1'b0;
    #1;
    chk("init pc", 14'h0000, pc_load);
    chk("init cause", 14'h0002, 14'(program_flag_register[7:6]));
    shadow_test();
    cyc();
    bank_wr <= 1'b1;
    bank_wdata <= 1'b1;
    cyc();
    bank_wr <= 1'b0;
    for (int i = 0; i < 8; i++) take_irq(i % 3, 14'h0100 + 14'(i));
    for (int i = 7; i >= 0; i--) do_ret(14'h0100 + 14'(i), 4'(i), 1'b1);
    do_ret(14'h0100, 4'h0, 1'b0);
    call_ret(14'h0345);
    masked_irq();
    take_irq(2, 14'h0222);
    hit_reset(0, 2'h2);
    hit_reset(1, 2'h0);
    hit_reset(2, 2'h3);
    print_verdict();
  end

  // Ends a hung run well after the expected hundred or so cycles.
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
endmodule : vect_core_tb
`default_nettype wire
